//--- core/fmt_pkg.sv
package fmt_pkg;
  localparam int unsigned NCH = 6;
  localparam int unsigned NOUT = 8;
  localparam int unsigned FRAC = 16;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [24:0] MS_US = 25'h00003E8;
  localparam logic [15:0] MAN_MS_MAX = 16'h4E20;
  // Offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TQ_CFG = 8'h04;
  localparam logic [7:0] A_SP_CFG = 8'h08;
  localparam logic [7:0] A_AN_CFG = 8'h0C;
  localparam logic [7:0] A_PW_CFG = 8'h10;
  localparam logic [7:0] A_ERR_CFG = 8'h14;
  localparam logic [7:0] A_RATED = 8'h18;
  localparam logic [7:0] A_MAP = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_MASK = 8'h24;
  localparam logic [7:0] A_FLAGS = 8'h28;
  localparam logic [7:0] A_ALIVE = 8'h2C;
  // Channel config fields: dp[2:0], sign[3], lp1[6:4], lp2[10:8]
  localparam int unsigned F_SIGN = 3;
  localparam int unsigned F_LP1 = 4;
  localparam int unsigned F_LP2 = 8;
  localparam logic [2:0] TQ_DP_MAX = 3'h5;
  localparam logic [2:0] SP_DP_MAX = 3'h3;
  // ERR_CFG: subst[1:0], auto[2], manual ms[31:16]
  localparam int unsigned F_AUTO = 2;
  localparam int unsigned F_MAN = 16;
  // Filter codes
  localparam logic [2:0] LP_0HZ1 = 3'h0;
  localparam logic [2:0] LP_1HZ = 3'h1;
  localparam logic [2:0] LP_10HZ = 3'h2;
  localparam logic [2:0] LP_100HZ = 3'h3;
  localparam logic [2:0] LP_1KHZ = 3'h4;
  localparam logic [2:0] LP_3KHZ = 3'h5;
  localparam logic [2:0] LP_OFF = 3'h6;
  localparam logic [2:0] LP_AVG = 3'h7;
  // Reset values
  localparam logic [31:0] RST_TQ_CFG = 32'h0000_0140;
  localparam logic [31:0] RST_SP_CFG = 32'h0000_0140;
  localparam logic [31:0] RST_AN_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_PW_CFG = 32'h0000_0020;
  localparam logic [31:0] RST_ERR_CFG = 32'h0000_0004;
  localparam logic [31:0] RST_RATED = 32'h0064_0000;
  localparam logic [7:0] RST_MAP = 8'hFF;
  typedef enum logic [1:0] {SUB_OVF = 2'h0, SUB_UNF = 2'h1, SUB_LAST = 2'h2, SUB_ACT = 2'h3} fmt_sub_t;
  localparam logic [31:0] CODE_OVF = 32'h7FFF_FFFF;
  localparam logic [31:0] CODE_UNF = 32'h8000_0000;
  // Dynamic error hold in microseconds, per filter code
  localparam logic [24:0] HOLD_0HZ1 = 25'h19BFCC0;
  localparam logic [24:0] HOLD_1HZ = 25'h00EE098;
  localparam logic [24:0] HOLD_10HZ = 25'h001FBD0;
  localparam logic [24:0] HOLD_100HZ = 25'h0002A94;
  localparam logic [24:0] HOLD_1KHZ = 25'h00004D3;
  localparam logic [24:0] HOLD_3KHZ = 25'h0000208;
  localparam logic [24:0] HOLD_NONE = 25'h0000000;
  // Low-pass smoothing shift per filter code
  localparam logic [4:0] SH_0HZ1 = 5'h10;
  localparam logic [4:0] SH_1HZ = 5'h0D;
  localparam logic [4:0] SH_10HZ = 5'h09;
  localparam logic [4:0] SH_100HZ = 5'h06;
  localparam logic [4:0] SH_1KHZ = 5'h03;
  localparam logic [4:0] SH_3KHZ = 5'h01;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} fmt_state_t;
endpackage

//--- core/fmt_lowpass.sv
`timescale 1ns/10ps
`default_nettype none
module fmt_lowpass
  import fmt_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic smp, // Sample strobe
  input wire logic [2:0] code, // Cutoff code
  input wire logic signed [31:0] x, // Input
  output logic signed [31:0] y // Filtered output
);
  logic signed [31:0] y_ff;
  logic signed [32:0] diff;
  logic [4:0] sh;
  logic byp;

  assign byp = (code == LP_OFF) || (code == LP_AVG);
  always_comb
  begin
    case (code)
      LP_0HZ1: sh = SH_0HZ1;
      LP_1HZ: sh = SH_1HZ;
      LP_10HZ: sh = SH_10HZ;
      LP_100HZ: sh = SH_100HZ;
      LP_1KHZ: sh = SH_1KHZ;
      default: sh = SH_3KHZ;
    endcase
  end
  assign diff = 33'(x) - 33'(y_ff);

  // Bypass keeps the state tracking so re-enabling starts without a step
  always_ff @(posedge clk)
  begin
    if (rst)
      y_ff <= '0;
    else if (smp)
      y_ff <= byp ? x : y_ff + 32'(diff >>> sh);
  end
  assign y = byp ? x : y_ff;

  property p_bypass;
    @(posedge clk) disable iff (rst) (code == LP_OFF) |-> (y == x);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass does not pass input");
endmodule
`default_nettype wire

//--- core/fmt_movavg.sv
`timescale 1ns/10ps
`default_nettype none
module fmt_movavg #(
  parameter int unsigned LOG_N = 4
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic on, // Filter selected
  input wire logic smp, // Angle-step sample strobe
  input wire logic signed [31:0] x, // Input
  output logic signed [31:0] y, // Output
  output logic filled // Window full
);
  localparam int unsigned N = 1 << LOG_N;
  initial
  begin
    if (LOG_N < 1 || LOG_N > 12)
      $error("LOG_N out of range");
  end
  logic signed [31:0] win [N];
  logic [LOG_N-1:0] wp_ff;
  logic [LOG_N:0] cnt_ff;
  logic signed [31+LOG_N+1:0] sum_ff;

  always_ff @(posedge clk)
  begin
    if (rst || !on)
    begin
      wp_ff <= '0;
      cnt_ff <= '0;
      sum_ff <= '0;
    end
    else if (smp)
    begin
      win[wp_ff] <= x;
      wp_ff <= wp_ff + 1'b1;
      if (!filled)
      begin
        cnt_ff <= cnt_ff + 1'b1;
        sum_ff <= sum_ff + (LOG_N+33)'(x);
      end
      else
        sum_ff <= sum_ff + (LOG_N+33)'(x) - (LOG_N+33)'(win[wp_ff]);
    end
  end
  assign filled = cnt_ff[LOG_N];
  // Raw input passes until the window holds N samples
  assign y = filled ? 32'(sum_ff >>> LOG_N) : x;

  property p_unfilled;
    @(posedge clk) disable iff (rst) !filled |-> (y == x);
  endproperty
  a_unfilled: assert property (p_unfilled)
    else $error("average acted before window filled");
endmodule
`default_nettype wire

//--- core/fmt_top.sv
// Behaviour
// - Moving average acts only once window full
// - Setting changes apply to next output
// - Output is value times ten to decimals
// - Torque decimals 0..5, speed 0..3
// - Two low-pass paths, listed cutoffs, defaults
// - Speed path one offers moving average
// - Settings rejected while parameter set locked; object map (A_MAP) writes are still accepted
// - Settings volatile, lost on reset
// - All objects sent by default, remappable
// - Invalid value replaced by chosen substitute
// - Torque invalid above 120% or link fault
// - Hold time automatic or manual 0..20000 ms
// - Auto: dynamic by filter, static until gone
// - Auto hold durations per filter table
// - Filter off bypasses the value
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module fmt_top
  import fmt_pkg::*;
#(
  parameter int unsigned AVG_LOG_N = 4
) (
  input wire logic clk, // Clock 125 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic smp, // New measurement sample
  input wire logic signed [31:0] torque_in, // Torque Q16.16
  input wire logic signed [31:0] speed_in, // Speed Q16.16
  input wire logic signed [31:0] angle_in, // Angle Q16.16
  input wire logic signed [31:0] power_in, // Power Q16.16
  input wire logic angle_step, // Angle increment strobe
  input wire logic speed_ovr, // Speed out of range
  input wire logic link_fault_pin, // Rotor link failure pin
  input wire logic [3:0] static_err_pin, // Static errors tq,sp,an,pw
  input wire logic frame_req, // Fieldbus frame request
  output logic pdo_valid, // Process data word valid
  output logic [2:0] pdo_index, // Object index
  output logic [31:0] pdo_data, // Object value
  output logic frame_done, // Frame finished
  output logic irq // Interrupt level
);
  logic [31:0] ctrl_ff, tq_ff, sp_ff, an_ff, pw_ff, ecfg_ff, rated_ff;
  logic [7:0] map_ff;
  logic [3:0] stat_ff, mask_ff;
  logic [31:0] alive_ff;
  logic [1:0] link_s_ff;
  logic [7:0] stat_s_ff;
  logic link_fault;
  logic [3:0] static_err;
  logic wr, rd, locked, cfg_ok, rej;
  logic [6:0] us_cnt_ff;
  logic us_tick;
  logic signed [31:0] raw [NCH];
  logic signed [31:0] filt [NCH];
  logic [2:0] dp_c [NCH];
  logic sg_c [NCH];
  logic [2:0] fc_c [NCH];
  logic [5:0] dyn, stat_c, err;
  logic [24:0] hold_ff [NCH];
  logic signed [31:0] last_ff [NCH];
  logic signed [31:0] scl [NCH];
  logic [31:0] val [NOUT];
  logic [5:0] err_d_ff;
  logic avg_fill, avg_fill_d_ff;
  logic signed [31:0] avg_y;
  logic [32:0] tq_abs, tq_lim;
  logic tq_over;
  fmt_state_t st_ff;
  logic [2:0] idx_ff;

  // Pins from outside the clock domain
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_s_ff <= '0;
      stat_s_ff <= '0;
    end
    else
    begin
      link_s_ff <= {link_s_ff[0], link_fault_pin};
      stat_s_ff <= {stat_s_ff[3:0], static_err_pin};
    end
  end
  assign link_fault = link_s_ff[1];
  assign static_err = stat_s_ff[7:4];

  always_ff @(posedge clk)
  begin
    if (rst || us_tick)
      us_cnt_ff <= '0;
    else
      us_cnt_ff <= us_cnt_ff + 1'b1;
  end
  assign us_tick = (us_cnt_ff == 7'(US_CYC - 1));

  // APB slave: zero wait states
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign locked = !ctrl_ff[0];
  always_comb
  begin
    cfg_ok = 1'b1;
    if (paddr == A_TQ_CFG)
      cfg_ok = pwdata[2:0] <= TQ_DP_MAX;
    else if (paddr == A_SP_CFG)
      cfg_ok = pwdata[2:0] <= SP_DP_MAX;
    else if (paddr == A_AN_CFG || paddr == A_PW_CFG)
      cfg_ok = pwdata[2:0] <= TQ_DP_MAX;
    else if (paddr == A_ERR_CFG)
      cfg_ok = pwdata[31:16] <= MAN_MS_MAX;
  end
  assign rej = wr && (paddr >= A_TQ_CFG) && (paddr <= A_RATED) && (locked || !cfg_ok);

  // Registers reset to defaults: nothing survives a reset cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff <= '0;
      tq_ff <= RST_TQ_CFG;
      sp_ff <= RST_SP_CFG;
      an_ff <= RST_AN_CFG;
      pw_ff <= RST_PW_CFG;
      ecfg_ff <= RST_ERR_CFG;
      rated_ff <= RST_RATED;
      map_ff <= RST_MAP;
      mask_ff <= '0;
    end
    else if (wr && !rej)
    begin
      if (paddr == A_CTRL)
        ctrl_ff <= {31'h0, pwdata[0]};
      else if (paddr == A_TQ_CFG)
        tq_ff <= {21'h0, pwdata[10:8], 1'b0, pwdata[6:0]};
      else if (paddr == A_SP_CFG)
        sp_ff <= {21'h0, pwdata[10:8], 1'b0, pwdata[6:0]};
      else if (paddr == A_AN_CFG)
        an_ff <= {28'h0, pwdata[3:0]};
      else if (paddr == A_PW_CFG)
        pw_ff <= {25'h0, pwdata[6:0]};
      else if (paddr == A_ERR_CFG)
        ecfg_ff <= {pwdata[31:16], 13'h0, pwdata[2:0]};
      else if (paddr == A_RATED)
        rated_ff <= pwdata;
      else if (paddr == A_MAP)
        map_ff <= pwdata[7:0];
      else if (paddr == A_MASK)
        mask_ff <= pwdata[3:0];
    end
  end

  always_comb
  begin
    prdata = '0;
    pslverr = 1'b0;
    if (paddr == A_CTRL)
      prdata = ctrl_ff;
    else if (paddr == A_TQ_CFG)
      prdata = tq_ff;
    else if (paddr == A_SP_CFG)
      prdata = sp_ff;
    else if (paddr == A_AN_CFG)
      prdata = an_ff;
    else if (paddr == A_PW_CFG)
      prdata = pw_ff;
    else if (paddr == A_ERR_CFG)
      prdata = ecfg_ff;
    else if (paddr == A_RATED)
      prdata = rated_ff;
    else if (paddr == A_MAP)
      prdata = {24'h0, map_ff};
    else if (paddr == A_STAT)
      prdata = {28'h0, stat_ff};
    else if (paddr == A_MASK)
      prdata = {28'h0, mask_ff};
    else if (paddr == A_FLAGS)
      prdata = {26'h0, err};
    else if (paddr == A_ALIVE)
      prdata = alive_ff;
    else
      pslverr = psel && penable;
  end

  // Status: frame done, error rise, rejected write, average filled
  logic [3:0] ev;
  assign ev = {avg_fill && !avg_fill_d_ff, rej, |(err & ~err_d_ff), frame_done};
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_ff <= '0;
      err_d_ff <= '0;
      avg_fill_d_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= (stat_ff & ~((wr && paddr == A_STAT) ? pwdata[3:0] : 4'h0)) | ev;
      err_d_ff <= err;
      avg_fill_d_ff <= avg_fill;
    end
  end
  assign irq = |(stat_ff & mask_ff);

  // Channels: torque p1, torque p2, speed p1, speed p2, angle, power
  assign raw[0] = torque_in;
  assign raw[1] = torque_in;
  assign raw[2] = speed_in;
  assign raw[3] = speed_in;
  assign raw[4] = angle_in;
  assign raw[5] = power_in;
  assign dp_c = '{tq_ff[2:0], tq_ff[2:0], sp_ff[2:0], sp_ff[2:0], an_ff[2:0], pw_ff[2:0]};
  assign sg_c = '{tq_ff[F_SIGN], tq_ff[F_SIGN], sp_ff[F_SIGN], sp_ff[F_SIGN],
                  an_ff[F_SIGN], pw_ff[F_SIGN]};
  assign fc_c = '{tq_ff[F_LP1+:3], tq_ff[F_LP2+:3], sp_ff[F_LP1+:3], sp_ff[F_LP2+:3],
                  LP_OFF, pw_ff[F_LP1+:3]};

  assign tq_abs = torque_in[31] ? 33'(-torque_in) : 33'(torque_in);
  assign tq_lim = 33'(rated_ff) + 33'(rated_ff / 5);
  assign tq_over = tq_abs > tq_lim;
  assign dyn = {tq_over || link_fault || speed_ovr, 1'b0, {2{speed_ovr}},
                {2{tq_over || link_fault}}};
  assign stat_c = {static_err[3], static_err[2], {2{static_err[1]}}, {2{static_err[0]}}};

  fmt_movavg #(
    .LOG_N(AVG_LOG_N)
  ) u_avg (
    .clk(clk),
    .rst(rst),
    .on(fc_c[2] == LP_AVG),
    .smp(smp && angle_step),
    .x(speed_in),
    .y(avg_y),
    .filled(avg_fill)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic signed [31:0] lp_y;
      logic signed [48:0] prod;
      logic signed [17:0] p10;
      logic [24:0] dur;
      logic [1:0] sub;
      fmt_lowpass u_lp (
        .clk(clk),
        .rst(rst),
        .smp(smp),
        .code(fc_c[g]),
        .x(raw[g]),
        .y(lp_y)
      );
      assign filt[g] = (g == 2 && fc_c[g] == LP_AVG) ? avg_y : lp_y;
      always_comb
      begin
        case (dp_c[g])
          // One spare bit so the five-place factor stays positive
          3'h0: p10 = 18'sh00001;
          3'h1: p10 = 18'sh0000A;
          3'h2: p10 = 18'sh00064;
          3'h3: p10 = 18'sh003E8;
          3'h4: p10 = 18'sh02710;
          default: p10 = 18'sh186A0;
        endcase
      end
      // Combinational from live settings so the next frame already uses them
      assign prod = 49'(filt[g]) * 49'(p10);
      assign scl[g] = sg_c[g] ? -32'(prod >>> FRAC) : 32'(prod >>> FRAC);
      always_comb
      begin
        if (!ecfg_ff[F_AUTO])
          dur = 25'(ecfg_ff[31:F_MAN]) * MS_US;
        else
          case (fc_c[g])
            LP_0HZ1: dur = HOLD_0HZ1;
            LP_1HZ: dur = HOLD_1HZ;
            LP_10HZ: dur = HOLD_10HZ;
            LP_100HZ: dur = HOLD_100HZ;
            LP_1KHZ: dur = HOLD_1KHZ;
            LP_3KHZ: dur = HOLD_3KHZ;
            default: dur = HOLD_NONE;
          endcase
      end
      always_ff @(posedge clk)
      begin
        if (rst)
          hold_ff[g] <= '0;
        else if (dyn[g])
          hold_ff[g] <= dur;
        else if (us_tick && hold_ff[g] != 25'h0)
          hold_ff[g] <= hold_ff[g] - 1'b1;
      end
      // Static causes are not held, they clear the moment they go away
      assign err[g] = stat_c[g] || dyn[g] || (hold_ff[g] != 25'h0);
      always_ff @(posedge clk)
      begin
        if (rst)
          last_ff[g] <= '0;
        else if (!err[g])
          last_ff[g] <= scl[g];
      end
      assign sub = ecfg_ff[1:0];
      always_comb
      begin
        val[g] = scl[g];
        if (err[g])
          case (sub)
            SUB_OVF: val[g] = CODE_OVF;
            SUB_UNF: val[g] = CODE_UNF;
            SUB_LAST: val[g] = last_ff[g];
            default: val[g] = scl[g];
          endcase
      end
    end
  endgenerate
  assign val[6] = alive_ff;
  assign val[7] = {26'h0, err};

  // Frame walk over the mapped objects
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= ST_IDLE;
      idx_ff <= '0;
      alive_ff <= '0;
      pdo_valid <= 1'b0;
      pdo_index <= '0;
      pdo_data <= '0;
      frame_done <= 1'b0;
    end
    else
    begin
      pdo_valid <= 1'b0;
      frame_done <= 1'b0;
      case (st_ff)
        ST_IDLE:
        begin
          idx_ff <= '0;
          if (frame_req)
          begin
            st_ff <= ST_SEND;
            alive_ff <= alive_ff + 1'b1;
          end
        end
        ST_SEND:
        begin
          pdo_valid <= map_ff[idx_ff];
          pdo_index <= idx_ff;
          pdo_data <= val[idx_ff];
          idx_ff <= idx_ff + 1'b1;
          if (idx_ff == 3'(NOUT - 1))
          begin
            st_ff <= ST_IDLE;
            frame_done <= 1'b1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  property p_lock;
    @(posedge clk) disable iff (rst)
    (wr && locked && paddr == A_TQ_CFG) |=> $stable(tq_ff);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked write changed torque config");
  property p_dp;
    @(posedge clk) disable iff (rst) tq_ff[2:0] <= TQ_DP_MAX && sp_ff[2:0] <= SP_DP_MAX;
  endproperty
  a_dp: assert property (p_dp)
    else $error("decimal count out of range");
  property p_ovf;
    @(posedge clk) disable iff (rst) (err[0] && ecfg_ff[1:0] == SUB_OVF) |-> val[0] == CODE_OVF;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow substitute missing");
  property p_unf;
    @(posedge clk) disable iff (rst) (err[1] && ecfg_ff[1:0] == SUB_UNF) |-> val[1] == CODE_UNF;
  endproperty
  a_unf: assert property (p_unf)
    else $error("underflow substitute missing");
  property p_map;
    @(posedge clk) $fell(rst) |-> map_ff == 8'hFF;
  endproperty
  a_map: assert property (p_map)
    else $error("map not all objects after reset");
  property p_hold;
    @(posedge clk) disable iff (rst)
    (dyn[0] && ecfg_ff[F_AUTO] && fc_c[0] == LP_3KHZ) ##1 !dyn[0] |-> hold_ff[0] == HOLD_3KHZ;
  endproperty
  a_hold: assert property (p_hold)
    else $error("3 kHz hold is not 520 us");
  property p_over;
    @(posedge clk) disable iff (rst) tq_over |-> err[0] && err[1];
  endproperty
  a_over: assert property (p_over)
    else $error("torque overrange not flagged");
  property p_scale;
    @(posedge clk) disable iff (rst)
    (!err[4] && dp_c[4] == 3'h2) |-> scl[4] == (sg_c[4] ? -32'((49'(angle_in) * 49'sd100) >>> FRAC)
                                             : 32'((49'(angle_in) * 49'sd100) >>> FRAC));
  endproperty
  a_scale: assert property (p_scale)
    else $error("angle scaling wrong");
  property p_last;
    @(posedge clk) disable iff (rst) (!err[1] ##1 err[1]) |-> last_ff[1] == $past(scl[1]);
  endproperty
  a_last: assert property (p_last)
    else $error("last valid value not kept");
  c_frame: cover property (@(posedge clk) disable iff (rst) frame_done);
  c_rej: cover property (@(posedge clk) disable iff (rst) rej);
  c_fill: cover property (@(posedge clk) disable iff (rst) $rose(avg_fill));
  c_err: cover property (@(posedge clk) disable iff (rst) $fell(err[0]));
endmodule
`default_nettype wire

//--- bench/fmt_master.sv
`timescale 1ns/10ps
`default_nettype none
module fmt_master (
  input wire logic clk, // Clock
  output logic frame_req, // Frame request pulse
  input wire logic pdo_valid, // Word valid
  input wire logic [2:0] pdo_index, // Word index
  input wire logic [31:0] pdo_data, // Word value
  input wire logic frame_done // Frame end
);
  logic [31:0] got [8];
  logic vld [8];
  logic done;
  initial frame_req = 1'b0;
  always @(posedge clk)
  begin
    if (pdo_valid === 1'b1)
    begin
      got[pdo_index] = pdo_data;
      vld[pdo_index] = 1'b1;
    end
    if (frame_done === 1'b1)
      done = 1'b1;
  end
  // One frame in flight only; a new request waits for frame_done
  task automatic get_frame(output bit ok);
    int n;
    for (int i = 0; i < 8; i++)
      vld[i] = 1'b0;
    done = 1'b0;
    @(posedge clk);
    frame_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    ok = (done === 1'b1);
  endtask
endmodule
`default_nettype wire

//--- bench/measurement_output_formatter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module measurement_output_formatter_bench;
  import fmt_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, smp = 0, lf = 0, stp = 0;
  logic [3:0] se = 4'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pdo_data, r;
  logic pready, pslverr, pdo_valid, frame_done, irq, frame_req, e;
  logic [2:0] pdo_index;
  logic signed [31:0] tq = 0, sp = 0, an = 0, pw = 0;
  int fails = 0, cmp_count = 0, seed = 32'hb239bc7e, neg, lastv;
  bit ok;
  always #4 clk = ~clk;
  fmt_top #(.AVG_LOG_N(2)) fmt_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .smp(smp), .torque_in(tq), .speed_in(sp), .angle_in(an),
    .power_in(pw), .angle_step(stp), .speed_ovr(1'b0), .link_fault_pin(lf),
    .static_err_pin(se), .frame_req(frame_req), .pdo_valid(pdo_valid),
    .pdo_index(pdo_index), .pdo_data(pdo_data), .frame_done(frame_done), .irq(irq));
  fmt_master fmt_master_i (.clk(clk), .frame_req(frame_req), .pdo_valid(pdo_valid),
    .pdo_index(pdo_index), .pdo_data(pdo_data), .frame_done(frame_done));
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      give_verdict;
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask
  task frm;
    fmt_master_i.get_frame(ok);
    if (!ok)
    begin
      fails++;
      give_verdict;
    end
  endtask
  // Samples are held long enough for sync and bypass paths to settle
  task drive(input logic signed [31:0] t, input logic l);
    tq <= t;
    sp <= $random(seed) % 32'sh0040_0000;
    an <= $random(seed);
    pw <= $random(seed);
    lf <= l;
    repeat (6)
    begin
      @(posedge clk) smp <= 1'b1;
      @(posedge clk) smp <= 1'b0;
    end
  endtask
  function automatic logic [31:0] scl(input longint v, input int dp, input int ng);
    longint p = 1;
    for (int i = 0; i < dp; i++)
      p = p * 10;
    v = (v * p) >>> 16;
    if (ng != 0)
      v = -v;
    return v[31:0];
  endfunction
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc("ctrl", A_CTRL, 32'h0);
    rdc("tq_cfg", A_TQ_CFG, 32'h140);
    rdc("sp_cfg", A_SP_CFG, 32'h140);
    rdc("err_cfg", A_ERR_CFG, 32'h4);
    rdc("map", A_MAP, 32'hFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    frm;
    for (int i = 0; i < 8; i++)
      chk("default slot", {31'h0, fmt_master_i.vld[i]}, 32'h1);
    chk("alive count", fmt_master_i.got[6], 32'h1);
    $display("test defaults done");
    apb(1'b1, A_TQ_CFG, 32'h662);
    rdc("locked tq_cfg", A_TQ_CFG, 32'h140);
    apb(1'b0, A_STAT, 32'h0);
    chk("reject flag", {31'h0, r[2]}, 32'h1);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_AN_CFG, 32'h2);
    for (int dp = 0; dp < 6; dp++)
    begin
      neg = dp % 2;
      apb(1'b1, A_TQ_CFG, 32'h660 | (neg << 3) | dp);
      apb(1'b1, A_SP_CFG, 32'h660 | ((dp > 3) ? 3 : dp));
      drive($random(seed) % 32'sh0064_0000, 1'b0);
      frm;
      lastv = scl(tq, dp, neg);
      chk("torque path one", fmt_master_i.got[0], lastv);
      chk("torque path two", fmt_master_i.got[1], lastv);
      chk("speed path one", fmt_master_i.got[2], scl(sp, (dp > 3) ? 3 : dp, 0));
      chk("angle", fmt_master_i.got[4], scl(an, 2, 0));
    end
    apb(1'b1, A_TQ_CFG, 32'h666);
    rdc("tq dp six", A_TQ_CFG, 32'h66D);
    apb(1'b1, A_SP_CFG, 32'h664);
    rdc("sp dp four", A_SP_CFG, 32'h663);
    $display("test scaling done");
    // Torque path one on 3 kHz so the automatic hold is exercised; path two stays bypassed
    apb(1'b1, A_TQ_CFG, 32'h65D);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, A_ERR_CFG, 32'h4 | s);
      drive(32'sh00C8_0000, 1'b0);
      frm;
      chk("substitute", fmt_master_i.got[1], (s == 0) ? CODE_OVF : (s == 1) ? CODE_UNF :
        (s == 2) ? lastv : scl(tq, 5, 1));
    end
    apb(1'b1, A_ERR_CFG, 32'h5);
    drive(32'sh0001_0000, 1'b1);
    frm;
    chk("link fault", fmt_master_i.got[1], CODE_UNF);
    chk("fault flags", fmt_master_i.got[7], 32'h23);
    drive(32'sh0001_0000, 1'b0);
    frm;
    chk("recovered", fmt_master_i.got[1], scl(tq, 5, 1));
    chk("held flags", fmt_master_i.got[7], 32'h21);
    se <= 4'h4;
    drive(32'sh0001_0000, 1'b0);
    frm;
    chk("static error", fmt_master_i.got[4], CODE_UNF);
    se <= 4'h0;
    drive(32'sh0001_0000, 1'b0);
    frm;
    chk("static gone", fmt_master_i.got[4], scl(an, 2, 0));
    apb(1'b1, A_SP_CFG, 32'h670);
    stp <= 1'b1;
    drive(32'sh0001_0000, 1'b0);
    frm;
    chk("speed average", fmt_master_i.got[2], scl(sp, 0, 0));
    apb(1'b0, A_STAT, 32'h0);
    chk("window filled", {31'h0, r[3]}, 32'h1);
    $display("test errors done");
    apb(1'b1, A_MAP, 32'h5);
    frm;
    for (int i = 0; i < 8; i++)
      chk("remap slot", {31'h0, fmt_master_i.vld[i]}, (i == 0 || i == 2));
    apb(1'b1, A_STAT, 32'hF);
    apb(1'b1, A_MASK, 32'h1);
    @(negedge clk);
    chk("irq idle", {31'h0, irq}, 32'h0);
    frm;
    @(negedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, A_STAT, 32'h1);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test map and irq done");
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("tq_cfg after reset", A_TQ_CFG, 32'h140);
    rdc("ctrl after reset", A_CTRL, 32'h0);
    $display("test volatile done");
    give_verdict;
  end
endmodule
`default_nettype wire
